// file: test/fast_pulse_counter_control_bench.sv
// Self-checking bench of the fast pulse counter
`timescale 1ns/1ps
module fast_pulse_counter_control_bench
	import fpcc_pkg::*;
;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] busAddr = 8'h00;
	logic [31:0] busWrData = 32'h0000_0000;
	logic busWrite = 1'b0;
	logic busRead = 1'b0;
	logic [31:0] busRdData;
	logic pulseClockPin;
	logic pulseDirPin;
	logic pulseResetPin;
	logic runPulses = 1'b0;
	logic dirLevel = 1'b1;
	logic resetLevel = 1'b0;
	logic irq;
	logic compareOut;
	logic successOut;
	logic busyOut;
	int err_total = 0;
	int total_checks = 0;
	int seedDummy;
	int gateCycles;
	logic [31:0] rdVal;
	logic [31:0] base;
	logic [15:0] errCall [6] = '{16'h0206, 16'h0101, 16'h0102,
		16'h0104, 16'h0108, 16'h0108};
	logic [15:0] errCode [6] = '{STATUS_BAD_ID, STATUS_BAD_DIR,
		STATUS_BAD_COUNT, STATUS_BAD_COMPARE, STATUS_BAD_GATE,
		STATUS_BAD_GATE};

	always #50 clock = ~clock;

	// Short gates keep the frequency runs brief
	fpcc_counter #(.GATE_10MS(40), .GATE_100MS(80), .GATE_1S(160))
	fpcc_counter_inst (.clock(clock), .reset_n(reset_n),
		.busAddr(busAddr), .busWrData(busWrData), .busWrite(busWrite),
		.busRead(busRead), .busRdData(busRdData),
		.pulseClockPin(pulseClockPin), .pulseDirPin(pulseDirPin),
		.pulseResetPin(pulseResetPin), .irq(irq),
		.compareOut(compareOut), .successOut(successOut),
		.busyOut(busyOut));

	fpcc_pulse_model #(.HALF(4)) fpcc_pulse_model_inst (.clock(clock),
		.reset_n(reset_n), .runPulses(runPulses), .dirLevel(dirLevel),
		.resetLevel(resetLevel), .pulseClockPin(pulseClockPin),
		.pulseDirPin(pulseDirPin), .pulseResetPin(pulseResetPin));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		busWrite <= 1'b1;
		busAddr <= a;
		busWrData <= d;
		@(posedge clock);
		busWrite <= 1'b0;
	endtask : wr

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp,
		input string what);
		@(posedge clock);
		busRead <= 1'b1;
		busAddr <= a;
		@(posedge clock);
		busRead <= 1'b0;
		// Data stand for one cycle after the read edge; take them at its end
		@(posedge clock);
		rdVal = busRdData;
		chk(what, rdVal, exp);
	endtask : rdChk

	// A call answers one edge after it is taken
	task automatic call(input logic [15:0] d, input logic [15:0] code);
		wr(ADDR_CALL, {16'h0000, d});
		@(posedge clock);
		rdChk(ADDR_RESULT, {15'h0000, code == STATUS_OK, code}, "result");
		chk("success", {31'h0, successOut}, {31'h0, code == STATUS_OK});
	endtask : call

	// Whole pulses, then room for the pin synchroniser
	task automatic pulses(input int n);
		@(posedge clock);
		runPulses <= 1'b1;
		repeat (8 * n) @(posedge clock);
		runPulses <= 1'b0;
		repeat (6) @(posedge clock);
	endtask : pulses

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		conclude();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		seedDummy = $urandom(57338);
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		rdChk(ADDR_CONFIG, 32'h0000_0000, "config");
		rdChk(ADDR_COMPARE, COMPARE_RESET, "compare reset");
		rdChk(ADDR_COUNT, 32'h0000_0000, "count reset");
		rdChk(ADDR_MASK, 32'h0000_0000, "mask reset");
		rdChk(ADDR_RESULT, 32'h0001_0000, "result reset");
		rdChk(8'h30, 32'h0000_0000, "unmapped");
		base = 32'($urandom_range(1000, 10));
		wr(ADDR_NEXT_COUNT, base);
		wr(ADDR_NEXT_COMPARE, base + 32'h0000_0003);
		call(16'h0106, STATUS_OK);
		rdChk(ADDR_COUNT, base, "preload");
		rdChk(ADDR_COMPARE, base + 32'h0000_0003, "compare");
		chk("below", {31'h0, compareOut}, 32'h1);
		wr(ADDR_MASK, 32'h0000_0001);
		pulses(3);
		rdChk(ADDR_COUNT, base + 32'h0000_0003, "count up");
		chk("below", {31'h0, compareOut}, 32'h0);
		chk("irq", {31'h0, irq}, 32'h1);
		rdChk(ADDR_EVENTS, 32'h0000_0001, "match event");
		rdChk(ADDR_EVENTS, 32'h0000_0000, "events cleared");
		chk("irq", {31'h0, irq}, 32'h0);
		wr(ADDR_NEXT_COUNT, $urandom);
		wr(ADDR_NEXT_COMPARE, base + 32'h0000_0040);
		wr(ADDR_NEXT_DIR, {16'h0000, DIR_DOWN});
		call(16'h0104, STATUS_OK);
		rdChk(ADDR_COUNT, base + 32'h0000_0003, "no preload");
		call(16'h0101, STATUS_OK);
		pulses(2);
		rdChk(ADDR_COUNT, base + 32'h0000_0001, "count down");
		rdChk(ADDR_EVENTS, 32'h0000_0004, "dir event");
		wr(ADDR_NEXT_COUNT, 32'hFFFF_FFFB);
		wr(ADDR_NEXT_COMPARE, 32'h0000_0002);
		call(16'h0106, STATUS_OK);
		chk("signed below", {31'h0, compareOut}, 32'h1);
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_CONFIG, (i >= 2 && i <= 4) ? 32'h2 : 32'h0);
			wr(ADDR_NEXT_DIR, (i == 1) ? 32'h2 : 32'h1);
			wr(ADDR_NEXT_GATE, (i == 4) ? 32'h3 : 32'h0);
			call(errCall[i], errCode[i]);
		end
		wr(ADDR_CONFIG, 32'h0000_0000);
		rdChk(ADDR_COUNT, 32'hFFFF_FFFB, "no load on error");
		wr(ADDR_NEXT_COUNT, 32'h0000_0009);
		@(posedge clock);
		busWrite <= 1'b1;
		busAddr <= ADDR_CALL;
		busWrData <= 32'h0000_0106;
		repeat (2) @(posedge clock);
		busWrite <= 1'b0;
		@(posedge clock);
		rdChk(ADDR_RESULT, {16'h0000, STATUS_CLASH}, "clash");
		rdChk(ADDR_COUNT, 32'hFFFF_FFFB, "clash no load");
		wr(ADDR_CONFIG, 32'h0000_0001);
		wr(ADDR_NEXT_DIR, {16'h0000, DIR_DOWN});
		call(16'h0101, STATUS_OK);
		pulses(2);
		rdChk(ADDR_COUNT, 32'hFFFF_FFFD, "pin direction");
		rdChk(ADDR_MASK, 32'h0000_0001, "mask");
		wr(ADDR_CONFIG, 32'h0000_0004);
		wr(ADDR_MASK, 32'h0000_0002);
		resetLevel <= 1'b1;
		pulses(2);
		rdChk(ADDR_COUNT, 32'h0000_0000, "held at zero");
		chk("reset irq", {31'h0, irq}, 32'h1);
		resetLevel <= 1'b0;
		wr(ADDR_CONFIG, 32'h0000_0002);
		for (int s = 0; s < 3; s++) begin
			gateCycles = 40 << s;
			wr(ADDR_NEXT_GATE, 32'(s));
			call(16'h0108, STATUS_OK);
			runPulses <= 1'b1;
			repeat (2 * gateCycles + 20) @(posedge clock);
			rdChk(ADDR_FREQ, 32'((gateCycles / 8) * ((s == 0) ? SCALE_10MS :
				(s == 1) ? SCALE_100MS : SCALE_1S)), "freq");
			runPulses <= 1'b0;
		end
		chk("busy", {31'h0, busyOut}, 32'h0);
		conclude();
	end
endmodule : fast_pulse_counter_control_bench

// file: test/fpcc_pulse_model.sv
// Pulse source model standing in for the encoder on the counter pins
`timescale 1ns/1ps
module fpcc_pulse_model #(
	parameter int HALF = 4
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic runPulses,
	input wire logic dirLevel,
	input wire logic resetLevel,
	output logic pulseClockPin,
	output logic pulseDirPin,
	output logic pulseResetPin
);
	typedef struct packed {
		logic [7:0] phase;
		logic clk;
	} fpcc_src_type;
	fpcc_src_type state_q;
	fpcc_src_type state_d;

	// ****************************************************************
	// Square wave of 2*HALF cycles while running
	// ****************************************************************
	// Stopping always lands the pin low, so every burst has whole pulses
	always_comb begin
		state_d = state_q;
		if (!runPulses) begin
			state_d.phase = 8'h00;
		end else if (state_q.phase == 8'(2 * HALF - 1)) begin
			state_d.phase = 8'h00;
		end else begin
			state_d.phase = state_q.phase + 8'h01;
		end
		state_d.clk = runPulses && (state_d.phase >= 8'(HALF));
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign pulseClockPin = state_q.clk;
	assign pulseDirPin = dirLevel;
	assign pulseResetPin = resetLevel;
endmodule : fpcc_pulse_model

// file: verilog/fpcc_counter.sv
// Fast pulse counter with control call, compare, events and frequency
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps

module fpcc_counter
	import fpcc_pkg::*;
#(
	parameter logic [7:0] COUNTER_ID = 8'h01, // Arbitrary identifier
	parameter int GATE_10MS = GATE_10MS_CYCLES,
	parameter int GATE_100MS = GATE_100MS_CYCLES,
	parameter int GATE_1S = GATE_1S_CYCLES
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] busAddr,
	input wire logic [31:0] busWrData,
	input wire logic busWrite,
	input wire logic busRead,
	output logic [31:0] busRdData,
	input wire logic pulseClockPin,
	input wire logic pulseDirPin,
	input wire logic pulseResetPin,
	output logic irq,
	output logic compareOut,
	output logic successOut,
	output logic busyOut
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (GATE_10MS < 1 || GATE_100MS < 1 || GATE_1S < 1 ||
		GATE_10MS >= 2 ** 24 || GATE_100MS >= 2 ** 24 ||
		GATE_1S >= 2 ** 24) begin : gBadGate
		$error("Gate period counts must lie in 1 to 2**24-1");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [2:0] setup;
		logic [15:0] nextDir;
		logic [31:0] nextCount;
		logic [31:0] nextCompare;
		logic [15:0] nextGate;
		logic callPending;
		logic [3:0] callReq;
		logic [7:0] callId;
		logic dirUp;
		logic prevDirUp;
		logic prevClk;
		logic prevRst;
		logic signed [31:0] count;
		logic signed [31:0] compare;
		logic [1:0] gateSel;
		logic [23:0] gateCnt;
		logic [31:0] pulseAcc;
		logic [31:0] freq;
		logic [15:0] status;
		logic success;
		logic busy;
		logic [2:0] events;
		logic [2:0] mask;
		logic [31:0] rdData;
		logic irq;
		logic compareOut;
	} fpcc_state_type;

	fpcc_state_type s_q;
	fpcc_state_type s_d;

	logic [2:0] syncIn;
	logic clkRise;
	logic rstLevel;
	logic callWrite;
	logic clash;
	logic loadOk;
	logic effDirUp;
	logic extDir;
	logic freqMode;
	logic [15:0] callStatus;
	logic [23:0] gateLimit;
	logic [31:0] accNext;
	logic [2:0] evtSet;
	logic [2:0] evtClear;

	fpcc_sync #(
		.WIDTH(3)
	) uSync (
		.clock(clock),
		.reset_n(reset_n),
		.pinIn({pulseResetPin, pulseDirPin, pulseClockPin}),
		.syncOut(syncIn)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		s_d = s_q;
		extDir = s_q.setup[CFG_EXT_DIR_BIT];
		freqMode = s_q.setup[CFG_FREQ_MODE_BIT];
		clkRise = syncIn[SYNC_CLK_BIT] & ~s_q.prevClk;
		// External reset only exists in counting mode
		rstLevel = syncIn[SYNC_RST_BIT] & s_q.setup[CFG_RESET_EN_BIT] &
			~freqMode;
		callWrite = busWrite && (busAddr == ADDR_CALL);
		clash = s_q.callPending & callWrite;
		evtSet = 3'h0;
		evtClear = 3'h0;
		s_d.prevClk = syncIn[SYNC_CLK_BIT];
		s_d.prevRst = rstLevel;
		s_d.busy = 1'b0;

		// Checks of a pending call, first failure wins
		callStatus = STATUS_OK;
		if (s_q.callId != COUNTER_ID) begin
			callStatus = STATUS_BAD_ID;
		end else if (s_q.callReq[REQ_DIR_BIT] && !extDir &&
			s_q.nextDir != DIR_UP && s_q.nextDir != DIR_DOWN) begin
			callStatus = STATUS_BAD_DIR;
		end else if (s_q.callReq[REQ_COUNT_BIT] && freqMode) begin
			callStatus = STATUS_BAD_COUNT;
		end else if (s_q.callReq[REQ_COMPARE_BIT] && freqMode) begin
			callStatus = STATUS_BAD_COMPARE;
		end else if (s_q.callReq[REQ_GATE_BIT] && (!freqMode ||
			s_q.nextGate > {14'h0000, GATE_SEL_1S})) begin
			callStatus = STATUS_BAD_GATE;
		end
		// A failing call loads nothing at all
		loadOk = s_q.callPending & ~clash & (callStatus == STATUS_OK);

		// Register writes
		if (busWrite) begin
			if (busAddr == ADDR_CONFIG) begin
				s_d.setup = busWrData[2:0];
			end else if (busAddr == ADDR_NEXT_DIR) begin
				s_d.nextDir = busWrData[15:0];
			end else if (busAddr == ADDR_NEXT_COUNT) begin
				s_d.nextCount = busWrData;
			end else if (busAddr == ADDR_NEXT_COMPARE) begin
				s_d.nextCompare = busWrData;
			end else if (busAddr == ADDR_NEXT_GATE) begin
				s_d.nextGate = busWrData[15:0];
			end else if (busAddr == ADDR_MASK) begin
				s_d.mask = busWrData[2:0];
			end
		end

		// Control call: captured, executed in the next cycle
		if (s_q.callPending) begin
			s_d.callPending = 1'b0;
			s_d.status = clash ? STATUS_CLASH : callStatus;
			s_d.success = !clash && callStatus == STATUS_OK;
		end else if (callWrite) begin
			s_d.callPending = 1'b1;
			s_d.callReq = busWrData[3:0];
			s_d.callId = busWrData[CALL_ID_LSB+:8];
		end

		// Loads; every flagged one in the same cycle, direction only when extDir is clear
		if (loadOk && s_q.callReq[REQ_DIR_BIT] && !extDir) begin
			s_d.dirUp = (s_q.nextDir == DIR_UP);
		end
		if (loadOk && s_q.callReq[REQ_COMPARE_BIT]) begin
			s_d.compare = s_q.nextCompare;
		end
		effDirUp = extDir ? syncIn[SYNC_DIR_BIT] : s_d.dirUp;
		s_d.prevDirUp = effDirUp;

		// Count path
		if (clkRise && !freqMode) begin
			if (effDirUp) begin
				s_d.count = s_q.count + 32'sh0000_0001;
			end else begin
				s_d.count = s_q.count - 32'sh0000_0001;
			end
		end
		if (loadOk && s_q.callReq[REQ_COUNT_BIT]) begin
			s_d.count = s_q.nextCount;
		end
		if (rstLevel) begin
			s_d.count = 32'sh0000_0000;
		end

		// Frequency gate
		if (s_q.gateSel == GATE_SEL_10MS) begin
			gateLimit = 24'(GATE_10MS - 1);
		end else if (s_q.gateSel == GATE_SEL_100MS) begin
			gateLimit = 24'(GATE_100MS - 1);
		end else begin
			gateLimit = 24'(GATE_1S - 1);
		end
		accNext = s_q.pulseAcc + {31'h0000_0000, clkRise};
		if (loadOk && s_q.callReq[REQ_GATE_BIT]) begin
			s_d.gateSel = s_q.nextGate[1:0];
			s_d.gateCnt = 24'h00_0000;
			s_d.pulseAcc = 32'h0000_0000;
		end else if (!freqMode) begin
			s_d.gateCnt = 24'h00_0000;
			s_d.pulseAcc = 32'h0000_0000;
		end else if (s_q.gateCnt == gateLimit) begin
			// Scale to pulses per second whatever the period
			if (s_q.gateSel == GATE_SEL_10MS) begin
				s_d.freq = 32'(accNext * SCALE_10MS);
			end else if (s_q.gateSel == GATE_SEL_100MS) begin
				s_d.freq = 32'(accNext * SCALE_100MS);
			end else begin
				s_d.freq = 32'(accNext * SCALE_1S);
			end
			s_d.gateCnt = 24'h00_0000;
			s_d.pulseAcc = 32'h0000_0000;
		end else begin
			s_d.gateCnt = s_q.gateCnt + 24'h00_0001;
			s_d.pulseAcc = accNext;
		end

		// Events
		if (!freqMode && s_d.count != s_q.count &&
			s_d.count == s_d.compare) begin
			evtSet[EVT_MATCH_BIT] = 1'b1;
		end
		evtSet[EVT_RESET_BIT] = rstLevel & ~s_q.prevRst;
		evtSet[EVT_DIR_BIT] = effDirUp ^ s_q.prevDirUp;

		// Reads, data in the next cycle
		s_d.rdData = 32'h0000_0000;
		if (busRead) begin
			if (busAddr == ADDR_CONFIG) begin
				s_d.rdData = {29'h0000_0000, s_q.setup};
			end else if (busAddr == ADDR_NEXT_DIR) begin
				s_d.rdData = {16'h0000, s_q.nextDir};
			end else if (busAddr == ADDR_NEXT_COUNT) begin
				s_d.rdData = s_q.nextCount;
			end else if (busAddr == ADDR_NEXT_COMPARE) begin
				s_d.rdData = s_q.nextCompare;
			end else if (busAddr == ADDR_NEXT_GATE) begin
				s_d.rdData = {16'h0000, s_q.nextGate};
			end else if (busAddr == ADDR_RESULT) begin
				s_d.rdData = {14'h0000, s_q.busy, s_q.success, s_q.status};
			end else if (busAddr == ADDR_COUNT) begin
				s_d.rdData = s_q.count;
			end else if (busAddr == ADDR_COMPARE) begin
				s_d.rdData = s_q.compare;
			end else if (busAddr == ADDR_FREQ) begin
				s_d.rdData = s_q.freq;
			end else if (busAddr == ADDR_EVENTS) begin
				s_d.rdData = {29'h0000_0000, s_q.events};
				evtClear = 3'h7;
			end else if (busAddr == ADDR_MASK) begin
				s_d.rdData = {29'h0000_0000, s_q.mask};
			end
		end
		// An event in the clearing read survives
		s_d.events = (s_q.events & ~evtClear) | evtSet;
		s_d.irq = |(s_d.events & s_d.mask);
		s_d.compareOut = s_d.count < s_d.compare;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.setup <= CONFIG_RESET;
			s_q.dirUp <= 1'b1;
			s_q.prevDirUp <= 1'b1;
			s_q.compare <= COMPARE_RESET;
			s_q.gateSel <= GATE_SEL_RESET;
			s_q.status <= STATUS_OK;
			s_q.success <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign busRdData = s_q.rdData;
	assign irq = s_q.irq;
	assign compareOut = s_q.compareOut;
	assign successOut = s_q.success;
	assign busyOut = s_q.busy;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	AST_DIR_LOAD: assert property (
		loadOk && s_q.callReq[REQ_DIR_BIT] && !extDir |=>
		s_q.dirUp == ($past(s_q.nextDir) == DIR_UP))
		else $error("Direction load not applied");
	AST_PRELOAD: assert property (
		loadOk && s_q.callReq[REQ_COUNT_BIT] && !rstLevel |=>
		s_q.count == $past(s_q.nextCount))
		else $error("Count preload not applied");
	AST_COMPARE_LOAD: assert property (
		loadOk && s_q.callReq[REQ_COMPARE_BIT] |=>
		s_q.compare == $past(s_q.nextCompare))
		else $error("Compare load not applied");
	AST_IGNORE: assert property (
		!(loadOk && s_q.callReq[REQ_COMPARE_BIT]) |=> $stable(s_q.compare))
		else $error("Reference changed without request");
	AST_EXT_DIR: assert property (
		extDir && s_q.callPending |=> $stable(s_q.dirUp))
		else $error("Direction loaded under external control");
	AST_BUSY: assert property (busyOut == 1'b0)
		else $error("Busy output not zero");
	AST_ERROR_FLAG: assert property (
		s_q.callPending |=> successOut == (s_q.status == STATUS_OK))
		else $error("Success flag disagrees with status");
	AST_BAD_ID: assert property (
		s_q.callPending && !clash && s_q.callId != COUNTER_ID |=>
		s_q.status == STATUS_BAD_ID ##1 !$rose(successOut))
		else $error("Wrong identifier not reported");
	AST_CLASH: assert property (
		clash |=> s_q.status == STATUS_CLASH && !successOut)
		else $error("Overlapping call not reported");
	AST_READ_COUNT: assert property (
		busRead && busAddr == ADDR_COUNT |=> busRdData == $past(s_q.count))
		else $error("Count read not the instant value");
	AST_RESET_HOLD: assert property (
		rstLevel [*2] |=> s_q.count == 32'sh0000_0000)
		else $error("Count not held at zero during reset");
	AST_CMP_OUT: assert property (
		compareOut == (s_q.count < s_q.compare))
		else $error("Compare output wrong");
	AST_MATCH_EVT: assert property (
		!freqMode && $changed(s_q.count) && s_q.count == s_q.compare |->
		s_q.events[EVT_MATCH_BIT])
		else $error("Match event missing");

	COV_MATCH: cover property (s_q.events[EVT_MATCH_BIT] && irq);
	COV_MULTI_LOAD: cover property (loadOk && s_q.callReq == 4'h6);
	COV_CLASH: cover property (clash);
	COV_FREQ: cover property (freqMode && s_q.gateCnt == gateLimit);

endmodule : fpcc_counter

// file: verilog/fpcc_pkg.sv
// Package with the register map, codes and timing of the pulse counter
package fpcc_pkg;

	// ****************************************************************
	// Register byte addresses
	// ****************************************************************
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_NEXT_DIR = 8'h04;
	localparam logic [7:0] ADDR_NEXT_COUNT = 8'h08;
	localparam logic [7:0] ADDR_NEXT_COMPARE = 8'h0C;
	localparam logic [7:0] ADDR_NEXT_GATE = 8'h10;
	localparam logic [7:0] ADDR_CALL = 8'h14;
	localparam logic [7:0] ADDR_RESULT = 8'h18;
	localparam logic [7:0] ADDR_COUNT = 8'h1C;
	localparam logic [7:0] ADDR_COMPARE = 8'h20;
	localparam logic [7:0] ADDR_FREQ = 8'h24;
	localparam logic [7:0] ADDR_EVENTS = 8'h28;
	localparam logic [7:0] ADDR_MASK = 8'h2C;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CFG_EXT_DIR_BIT = 0;
	localparam int CFG_FREQ_MODE_BIT = 1;
	localparam int CFG_RESET_EN_BIT = 2;
	localparam int REQ_DIR_BIT = 0;
	localparam int REQ_COUNT_BIT = 1;
	localparam int REQ_COMPARE_BIT = 2;
	localparam int REQ_GATE_BIT = 3;
	localparam int CALL_ID_LSB = 8;
	localparam int RESULT_SUCCESS_BIT = 16;
	localparam int RESULT_BUSY_BIT = 17;
	localparam int EVT_MATCH_BIT = 0;
	localparam int EVT_RESET_BIT = 1;
	localparam int EVT_DIR_BIT = 2;
	localparam int SYNC_CLK_BIT = 0;
	localparam int SYNC_DIR_BIT = 1;
	localparam int SYNC_RST_BIT = 2;

	// ****************************************************************
	// Codes and reset values
	// ****************************************************************
	localparam logic [15:0] DIR_UP = 16'h0001;
	localparam logic [15:0] DIR_DOWN = 16'hFFFF;
	localparam logic [15:0] STATUS_OK = 16'h0000;
	localparam logic [15:0] STATUS_BAD_ID = 16'h80A1;
	localparam logic [15:0] STATUS_BAD_DIR = 16'h80B1;
	localparam logic [15:0] STATUS_BAD_COUNT = 16'h80B2;
	localparam logic [15:0] STATUS_BAD_COMPARE = 16'h80B3;
	localparam logic [15:0] STATUS_BAD_GATE = 16'h80B4;
	localparam logic [15:0] STATUS_CLASH = 16'h80C0;
	localparam logic [1:0] GATE_SEL_10MS = 2'h0;
	localparam logic [1:0] GATE_SEL_100MS = 2'h1;
	localparam logic [1:0] GATE_SEL_1S = 2'h2;
	localparam logic [2:0] CONFIG_RESET = 3'h0;
	localparam logic [31:0] COMPARE_RESET = 32'h0000_0000;
	localparam logic [1:0] GATE_SEL_RESET = 2'h2;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int GATE_10MS_NS = 10_000_000;
	localparam int GATE_100MS_NS = 100_000_000;
	localparam int GATE_1S_NS = 1_000_000_000;
	localparam int GATE_10MS_CYCLES = GATE_10MS_NS / CLOCK_PERIOD_NS;
	localparam int GATE_100MS_CYCLES = GATE_100MS_NS / CLOCK_PERIOD_NS;
	localparam int GATE_1S_CYCLES = GATE_1S_NS / CLOCK_PERIOD_NS;
	localparam int SCALE_10MS = 100;
	localparam int SCALE_100MS = 10;
	localparam int SCALE_1S = 1;

endpackage : fpcc_pkg

// file: verilog/fpcc_sync.sv
// Two-stage synchroniser for the pulse source pins
`timescale 1ns/1ps
module fpcc_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] syncOut
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} fpcc_sync_type;

	fpcc_sync_type s_q;
	fpcc_sync_type s_d;

	// The first stage feeds only the second stage
	always_comb begin
		s_d = s_q;
		s_d.first = pinIn;
		s_d.second = s_q.first;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign syncOut = s_q.second;

endmodule : fpcc_sync
